// ### shared/dbpc_pkg.sv
// dbpc_pkg: register indices, mode fields and types of the
// buffer-process controller.
// assumes byte address = index * 4 on a 32-bit apb bus.
package dbpc_pkg;

  // apb address width and index width
  localparam int AW = 12;
  localparam int IW = 10;

  // command ports, any write triggers
  localparam logic [IW-1:0] IX_BPTR_CLR  = 10'h00c;
  localparam logic [IW-1:0] IX_MCLR      = 10'h00d;
  localparam logic [IW-1:0] IX_MASK0_CLR = 10'h00e;
  localparam logic [IW-1:0] IX_TCIRQ_CLR = 10'h01e;
  localparam logic [IW-1:0] IX_MASK1_CLR = 10'h0ce;

  // control and channel ports
  localparam logic [IW-1:0] IX_CH_SEL   = 10'h040;
  localparam logic [IW-1:0] IX_MODE1    = 10'h041;
  localparam logic [IW-1:0] IX_CHAIN    = 10'h042;
  localparam logic [IW-1:0] IX_MASK     = 10'h043;
  localparam logic [IW-1:0] IX_SWREQ    = 10'h044;
  localparam logic [IW-1:0] IX_STATUS   = 10'h045;
  localparam logic [IW-1:0] IX_TGT_PAIR = 10'h046;
  localparam logic [IW-1:0] IX_TGT_B2   = 10'h047;
  localparam logic [IW-1:0] IX_TGT_B3   = 10'h048;
  localparam logic [IW-1:0] IX_CNT_PAIR = 10'h049;
  localparam logic [IW-1:0] IX_CNT_B2   = 10'h04a;
  localparam logic [IW-1:0] IX_REQ_ADDR = 10'h04b;
  localparam logic [IW-1:0] IX_HOLD     = 10'h04c;

  // mode register one fields
  localparam int MD_XF_LSB  = 6;
  localparam int MD_AUTO    = 4;
  localparam int MD_DST_REQ = 0;
  localparam logic [7:0] MODE1_RST = 8'h00;

  // status word fields
  localparam int ST_HWREQ_LSB = 8;
  localparam int ST_TCIRQ     = 16;
  localparam int ST_BUSY      = 17;

  // widths
  localparam int CNT_W      = 24;
  localparam int HOLD_BYTES = 4;

  typedef enum logic [1:0] {
    XF_DEMAND, XF_SINGLE, XF_BLOCK, XF_CASCADE
  } dbpc_xfer_t;

  typedef enum logic [1:0] {
    S_IDLE, S_FETCH, S_STORE
  } dbpc_state_t;

endpackage

// ### core/dbpc_ctrl.sv
// dbpc_ctrl: per-channel dma buffer-process controller with apb
// registers, holding registers and a byte-wide transfer engine.
// assumes a memory-side agent on pclk answering acc_req with acc_ack.
//
// Overview of operation
// - each channel owns 32-bit holding register, order kept
// - requester destination early stop leaves holding intact
// - target destination eop flushes holding, maybe partial
// - unmasked channel starts on hardware or software request
// - mode and process kept across buffer expiries
// - no chaining, no autoinit gives single buffer
// - autoinit reloads current from base on expiry
// - entering chaining raises chaining interrupt at once
// - base target top byte load drops chaining interrupt
// - chained expiry reloads current and reasserts interrupt once base top byte was loaded, else masks channel
// - chaining disable ends chaining, drops pending interrupt
// - mask bit suspends chaining without leaving it
// - mode bits seven and six pick handshaking
// - cascade ignores other mode settings
// - five command ports act on any written data
// - command port clears byte pointer toggle
// - master clear resets control, mode and holding state, keeps addresses and counts
// - group mask clear commands enable channels 3..0 and NCH-1..4
// - command port clears terminal count interrupt flag
// - byte pointer toggles on paired byte accesses
// - of the target byte writes only the hidden top byte drops interrupt
`timescale 1ns/1ns
module dbpc_ctrl #(
  parameter int NCH = 8
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // request pins
  input  wire logic [NCH-1:0]     channel_request_in,
  input  wire logic               end_of_process_n,
  // access port towards target and requester
  output logic                    acc_req,
  output logic                    acc_write,
  output logic                    acc_to_target,
  output logic      [2:0]         acc_ch,
  output logic      [31:0]        acc_addr,
  output logic      [31:0]        acc_wdata,
  output logic      [2:0]         acc_bytes,
  input  wire logic               acc_ack,
  input  wire logic [7:0]         acc_rdata,
  // events
  output logic                    chaining_interrupt,
  output logic                    terminal_count,
  output logic                    tc_irq
);

  if (NCH < 5 || NCH > 8) begin : g_chk
    $error("dbpc_ctrl: NCH must lie in 5..8");
  end

  localparam int CW = dbpc_pkg::CNT_W;

  // synchronisers
  logic [NCH-1:0] req_m_q, req_s_q;
  logic           eop_m_q, eop_s_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_m_q <= '0;
      req_s_q <= '0;
      eop_m_q <= 1'b1;
      eop_s_q <= 1'b1;
    end
    else
    begin
      req_m_q <= channel_request_in;
      req_s_q <= req_m_q;
      eop_m_q <= end_of_process_n;
      eop_s_q <= eop_m_q;
    end
  end

  // channel state
  logic [7:0]    mode_q     [NCH];
  logic [31:0]   hold_q     [NCH];
  logic [2:0]    fill_q     [NCH];
  logic [31:0]   base_tgt_q [NCH];
  logic [31:0]   cur_tgt_q  [NCH];
  logic [31:0]   base_req_q [NCH];
  logic [31:0]   cur_req_q  [NCH];
  logic [CW-1:0] base_cnt_q [NCH];
  logic [CW-1:0] cur_cnt_q  [NCH];
  logic [NCH-1:0] mask_q, swreq_q, tc_q;
  logic [NCH-1:0] chain_en_q, chain_irq_q, base_ok_q;
  logic [2:0]     sel_q, act_ch_q;
  logic           bptr_q, tc_irq_q, exp_pend_q, by_sw_q;
  dbpc_pkg::dbpc_state_t state_q;

  // apb decode
  logic [9:0] ix;
  logic       done, wr, rd;
  assign ix   = paddr[11:2];
  assign done = psel && penable && pready;
  assign wr   = done && pwrite;
  assign rd   = done && !pwrite;

  logic cmd_mclr;
  assign cmd_mclr = wr && ix == dbpc_pkg::IX_MCLR;

  logic mapped;
  always_comb
  begin
    unique case (ix)
      dbpc_pkg::IX_BPTR_CLR, dbpc_pkg::IX_MCLR,
      dbpc_pkg::IX_MASK0_CLR, dbpc_pkg::IX_TCIRQ_CLR,
      dbpc_pkg::IX_MASK1_CLR, dbpc_pkg::IX_CH_SEL,
      dbpc_pkg::IX_MODE1, dbpc_pkg::IX_CHAIN, dbpc_pkg::IX_MASK,
      dbpc_pkg::IX_SWREQ, dbpc_pkg::IX_STATUS,
      dbpc_pkg::IX_TGT_PAIR, dbpc_pkg::IX_TGT_B2,
      dbpc_pkg::IX_TGT_B3, dbpc_pkg::IX_CNT_PAIR,
      dbpc_pkg::IX_CNT_B2, dbpc_pkg::IX_REQ_ADDR,
      dbpc_pkg::IX_HOLD: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read mux, channel registers read current values
  logic [31:0] rd_val;
  logic [7:0]  pair_lo, pair_hi;
  always_comb
  begin
    rd_val = '0;
    pair_lo = bptr_q ? cur_tgt_q[sel_q][15:8] : cur_tgt_q[sel_q][7:0];
    pair_hi = bptr_q ? cur_cnt_q[sel_q][15:8] : cur_cnt_q[sel_q][7:0];
    case (ix)
      dbpc_pkg::IX_CH_SEL:   rd_val[2:0] = sel_q;
      dbpc_pkg::IX_MODE1:    rd_val[7:0] = mode_q[sel_q];
      dbpc_pkg::IX_CHAIN:    rd_val[NCH-1:0] = chain_irq_q;
      dbpc_pkg::IX_MASK:     rd_val[NCH-1:0] = mask_q;
      dbpc_pkg::IX_SWREQ:    rd_val[NCH-1:0] = swreq_q;
      dbpc_pkg::IX_STATUS:
      begin
        rd_val[NCH-1:0] = tc_q;
        rd_val[dbpc_pkg::ST_HWREQ_LSB +: NCH] = req_s_q;
        rd_val[dbpc_pkg::ST_TCIRQ] = tc_irq_q;
        rd_val[dbpc_pkg::ST_BUSY] = state_q != dbpc_pkg::S_IDLE;
      end
      dbpc_pkg::IX_TGT_PAIR: rd_val[7:0] = pair_lo;
      dbpc_pkg::IX_TGT_B2:   rd_val[7:0] = cur_tgt_q[sel_q][23:16];
      dbpc_pkg::IX_TGT_B3:   rd_val[7:0] = cur_tgt_q[sel_q][31:24];
      dbpc_pkg::IX_CNT_PAIR: rd_val[7:0] = pair_hi;
      dbpc_pkg::IX_CNT_B2:   rd_val[7:0] = cur_cnt_q[sel_q][23:16];
      dbpc_pkg::IX_REQ_ADDR: rd_val = cur_req_q[sel_q];
      dbpc_pkg::IX_HOLD:     rd_val = hold_q[sel_q];
      default:               rd_val = '0;
    endcase
  end

  // apb response, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable)
        prdata <= pwrite ? '0 : rd_val;
    end
  end

  // byte pointer toggle
  logic pair_acc;
  assign pair_acc = done && (ix == dbpc_pkg::IX_TGT_PAIR ||
                             ix == dbpc_pkg::IX_CNT_PAIR);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bptr_q <= 1'b0;
    else if (cmd_mclr || (wr && ix == dbpc_pkg::IX_BPTR_CLR))
      bptr_q <= 1'b0;
    else if (pair_acc)
      bptr_q <= !bptr_q;
  end

  // arbitration, lowest channel first
  logic [NCH-1:0] elig;
  logic [2:0]     pick;
  logic           any_elig;
  always_comb
  begin
    pick = '0;
    for (int i = 0; i < NCH; i++)
      elig[i] = !mask_q[i] && (req_s_q[i] || swreq_q[i])
                && mode_q[i][dbpc_pkg::MD_XF_LSB +: 2]
                   != dbpc_pkg::XF_CASCADE
                && cur_cnt_q[i] != '0;
    for (int i = NCH - 1; i >= 0; i--)
      if (elig[i])
        pick = 3'(i);
    any_elig = |elig;
  end

  // engine decode for the active channel
  logic [7:0]  amode;
  logic [31:0] hold_nx;
  logic [2:0]  nfill;
  logic        dst_req, eop_now, last, store_now, still_req;
  logic        do_exp, is_single, is_demand;
  logic [1:0]  xfer;
  always_comb
  begin
    amode     = mode_q[act_ch_q];
    dst_req   = amode[dbpc_pkg::MD_DST_REQ];
    xfer      = amode[dbpc_pkg::MD_XF_LSB +: 2];
    is_single = xfer == dbpc_pkg::XF_SINGLE;
    is_demand = xfer == dbpc_pkg::XF_DEMAND;
    eop_now   = !eop_s_q;
    still_req = req_s_q[act_ch_q] || swreq_q[act_ch_q];
    nfill     = fill_q[act_ch_q] + 3'd1;
    hold_nx   = hold_q[act_ch_q];
    hold_nx[{fill_q[act_ch_q][1:0], 3'b000} +: 8] = acc_rdata;
    last      = cur_cnt_q[act_ch_q] == CW'(1) || eop_now;
    store_now = nfill == 3'(dbpc_pkg::HOLD_BYTES)
                || (last && !(eop_now && dst_req));
    do_exp    = acc_ack && ((state_q == dbpc_pkg::S_FETCH
                && last && !store_now)
                || (state_q == dbpc_pkg::S_STORE && exp_pend_q));
  end

  // transfer engine and channel registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= dbpc_pkg::S_IDLE;
      act_ch_q <= '0;
      sel_q <= '0;
      exp_pend_q <= 1'b0;
      by_sw_q <= 1'b0;
      acc_req <= 1'b0;
      acc_write <= 1'b0;
      acc_to_target <= 1'b0;
      acc_ch <= '0;
      acc_addr <= '0;
      acc_wdata <= '0;
      acc_bytes <= '0;
      mask_q <= '1;
      swreq_q <= '0;
      tc_q <= '0;
      tc_irq_q <= 1'b0;
      chain_en_q <= '0;
      chain_irq_q <= '0;
      base_ok_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        mode_q[i] <= dbpc_pkg::MODE1_RST;
        hold_q[i] <= '0;
        fill_q[i] <= '0;
        base_tgt_q[i] <= '0;
        cur_tgt_q[i] <= '0;
        base_req_q[i] <= '0;
        cur_req_q[i] <= '0;
        base_cnt_q[i] <= '0;
        cur_cnt_q[i] <= '0;
      end
    end
    else if (cmd_mclr)
    begin
      state_q <= dbpc_pkg::S_IDLE;
      exp_pend_q <= 1'b0;
      acc_req <= 1'b0;
      acc_write <= 1'b0;
      mask_q <= '1;
      swreq_q <= '0;
      tc_q <= '0;
      tc_irq_q <= 1'b0;
      chain_en_q <= '0;
      chain_irq_q <= '0;
      base_ok_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        mode_q[i] <= dbpc_pkg::MODE1_RST;
        hold_q[i] <= '0;
        fill_q[i] <= '0;
      end
    end
    else
    begin
      // host side writes, configuration persists
      if (rd && ix == dbpc_pkg::IX_STATUS)
        tc_q <= '0;
      if (wr)
      begin
        case (ix)
          dbpc_pkg::IX_CH_SEL:    sel_q <= pwdata[2:0];
          dbpc_pkg::IX_MODE1:     mode_q[sel_q] <= pwdata[7:0];
          dbpc_pkg::IX_MASK:      mask_q <= pwdata[NCH-1:0];
          dbpc_pkg::IX_MASK0_CLR: mask_q[3:0] <= '0;
          dbpc_pkg::IX_MASK1_CLR: mask_q[NCH-1:4] <= '0;
          dbpc_pkg::IX_TCIRQ_CLR: tc_irq_q <= 1'b0;
          dbpc_pkg::IX_SWREQ:     swreq_q[sel_q] <= pwdata[0];
          dbpc_pkg::IX_CHAIN:
          begin
            chain_en_q[sel_q] <= pwdata[0];
            if (pwdata[0] && !chain_en_q[sel_q])
            begin
              chain_irq_q[sel_q] <= 1'b1;
              base_ok_q[sel_q] <= 1'b0;
            end
            if (!pwdata[0])
              chain_irq_q[sel_q] <= 1'b0;
          end
          dbpc_pkg::IX_TGT_PAIR:
          begin
            base_tgt_q[sel_q][{bptr_q, 3'b000} +: 8] <= pwdata[7:0];
            if (!chain_en_q[sel_q])
              cur_tgt_q[sel_q][{bptr_q, 3'b000} +: 8] <= pwdata[7:0];
          end
          dbpc_pkg::IX_TGT_B2:
          begin
            base_tgt_q[sel_q][23:16] <= pwdata[7:0];
            if (!chain_en_q[sel_q])
              cur_tgt_q[sel_q][23:16] <= pwdata[7:0];
          end
          dbpc_pkg::IX_TGT_B3:
          begin
            base_tgt_q[sel_q][31:24] <= pwdata[7:0];
            chain_irq_q[sel_q] <= 1'b0;
            base_ok_q[sel_q] <= 1'b1;
            if (!chain_en_q[sel_q])
              cur_tgt_q[sel_q][31:24] <= pwdata[7:0];
          end
          dbpc_pkg::IX_CNT_PAIR:
          begin
            base_cnt_q[sel_q][{bptr_q, 3'b000} +: 8] <= pwdata[7:0];
            if (!bptr_q)
              base_cnt_q[sel_q][23:16] <= '0;
            if (!chain_en_q[sel_q])
            begin
              cur_cnt_q[sel_q][{bptr_q, 3'b000} +: 8] <= pwdata[7:0];
              if (!bptr_q)
                cur_cnt_q[sel_q][23:16] <= '0;
            end
          end
          dbpc_pkg::IX_CNT_B2:
          begin
            base_cnt_q[sel_q][23:16] <= pwdata[7:0];
            if (!chain_en_q[sel_q])
              cur_cnt_q[sel_q][23:16] <= pwdata[7:0];
          end
          dbpc_pkg::IX_REQ_ADDR:
          begin
            base_req_q[sel_q] <= pwdata;
            if (!chain_en_q[sel_q])
              cur_req_q[sel_q] <= pwdata;
          end
          default: ;
        endcase
      end

      // engine
      case (state_q)
        dbpc_pkg::S_IDLE:
          if (any_elig)
          begin
            state_q <= dbpc_pkg::S_FETCH;
            act_ch_q <= pick;
            by_sw_q <= swreq_q[pick];
            acc_req <= 1'b1;
            acc_write <= 1'b0;
            acc_ch <= pick;
            acc_to_target <= mode_q[pick][dbpc_pkg::MD_DST_REQ];
            acc_addr <= mode_q[pick][dbpc_pkg::MD_DST_REQ]
                        ? cur_tgt_q[pick] : cur_req_q[pick];
          end
        dbpc_pkg::S_FETCH:
          if (acc_ack)
          begin
            hold_q[act_ch_q] <= hold_nx;
            fill_q[act_ch_q] <= nfill;
            cur_cnt_q[act_ch_q] <= cur_cnt_q[act_ch_q] - CW'(1);
            if (dst_req)
              cur_tgt_q[act_ch_q] <= cur_tgt_q[act_ch_q] + 32'h0000_0001;
            else
              cur_req_q[act_ch_q] <= cur_req_q[act_ch_q] + 32'h0000_0001;
            exp_pend_q <= last;
            if (store_now)
            begin
              state_q <= dbpc_pkg::S_STORE;
              acc_write <= 1'b1;
              acc_to_target <= !dst_req;
              acc_addr <= dst_req ? cur_req_q[act_ch_q]
                                  : cur_tgt_q[act_ch_q];
              acc_wdata <= hold_nx;
              acc_bytes <= nfill;
            end
            else if (last || is_single || (is_demand && !still_req))
            begin
              state_q <= dbpc_pkg::S_IDLE;
              acc_req <= 1'b0;
            end
            else
            begin
              acc_to_target <= dst_req;
              acc_addr <= acc_addr + 32'h0000_0001;
            end
          end
        dbpc_pkg::S_STORE:
          if (acc_ack)
          begin
            hold_q[act_ch_q] <= '0;
            fill_q[act_ch_q] <= '0;
            exp_pend_q <= 1'b0;
            if (dst_req)
              cur_req_q[act_ch_q] <= cur_req_q[act_ch_q]
                                     + 32'(fill_q[act_ch_q]);
            else
              cur_tgt_q[act_ch_q] <= cur_tgt_q[act_ch_q]
                                     + 32'(fill_q[act_ch_q]);
            if (!exp_pend_q && !is_single && !mask_q[act_ch_q]
                && (still_req || !is_demand))
            begin
              state_q <= dbpc_pkg::S_FETCH;
              acc_write <= 1'b0;
              acc_to_target <= dst_req;
              acc_addr <= dst_req ? cur_tgt_q[act_ch_q]
                                  : cur_req_q[act_ch_q];
            end
            else
            begin
              state_q <= dbpc_pkg::S_IDLE;
              acc_req <= 1'b0;
              acc_write <= 1'b0;
            end
          end
        default: state_q <= dbpc_pkg::S_IDLE;
      endcase

      // buffer expiry, hardware sets win over host clears
      if (do_exp)
      begin
        tc_q[act_ch_q] <= 1'b1;
        swreq_q[act_ch_q] <= 1'b0;
        if (by_sw_q)
          tc_irq_q <= 1'b1;
        if (amode[dbpc_pkg::MD_AUTO])
        begin
          cur_cnt_q[act_ch_q] <= base_cnt_q[act_ch_q];
          cur_tgt_q[act_ch_q] <= base_tgt_q[act_ch_q];
          cur_req_q[act_ch_q] <= base_req_q[act_ch_q];
        end
        else if (chain_en_q[act_ch_q] && base_ok_q[act_ch_q])
        begin
          cur_cnt_q[act_ch_q] <= base_cnt_q[act_ch_q];
          cur_tgt_q[act_ch_q] <= base_tgt_q[act_ch_q];
          cur_req_q[act_ch_q] <= base_req_q[act_ch_q];
          base_ok_q[act_ch_q] <= 1'b0;
          chain_irq_q[act_ch_q] <= 1'b1;
        end
        else
          mask_q[act_ch_q] <= 1'b1;
      end
    end
  end

  // event outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chaining_interrupt <= 1'b0;
      terminal_count <= 1'b0;
      tc_irq <= 1'b0;
    end
    else
    begin
      chaining_interrupt <= |chain_irq_q;
      terminal_count <= do_exp;
      tc_irq <= tc_irq_q;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bptr_clear: assert property (
    wr && ix == dbpc_pkg::IX_BPTR_CLR |=> !bptr_q)
    else $error("byte pointer not cleared");
  a_bptr_toggle: assert property (
    pair_acc |=> bptr_q != $past(bptr_q))
    else $error("byte pointer did not toggle");
  a_chain_entry: assert property (
    wr && ix == dbpc_pkg::IX_CHAIN && pwdata[0]
    && !chain_en_q[sel_q] |=> ##1 chaining_interrupt)
    else $error("chaining interrupt not raised");
  a_chain_drop: assert property (
    wr && ix == dbpc_pkg::IX_TGT_B3 && !do_exp
    |=> !chain_irq_q[$past(sel_q)])
    else $error("chaining interrupt not removed");
  a_chain_exit: assert property (
    wr && ix == dbpc_pkg::IX_CHAIN && !pwdata[0] && !do_exp
    |=> !chain_irq_q[$past(sel_q)] && !chain_en_q[$past(sel_q)])
    else $error("chaining exit incomplete");
  a_mask_group: assert property (
    wr && ix == dbpc_pkg::IX_MASK0_CLR && !do_exp
    |=> mask_q[3:0] == '0)
    else $error("group mask not cleared");
  a_mclr_state: assert property (
    cmd_mclr |=> mask_q == '1 && chain_irq_q == '0
    && state_q == dbpc_pkg::S_IDLE ##1 !chaining_interrupt)
    else $error("master clear incomplete");
  a_tcirq_clr: assert property (
    wr && ix == dbpc_pkg::IX_TCIRQ_CLR && !do_exp |=> ##1 !tc_irq)
    else $error("tc interrupt flag not cleared");
  a_hold_kept: assert property (
    state_q == dbpc_pkg::S_FETCH && acc_ack && eop_now && dst_req
    && !store_now && !cmd_mclr |=> state_q == dbpc_pkg::S_IDLE && !acc_req
    && hold_q[act_ch_q] == $past(hold_nx))
    else $error("holding register disturbed");
  a_flush_target: assert property (
    state_q == dbpc_pkg::S_FETCH && acc_ack && eop_now && !dst_req
    && !cmd_mclr |=> acc_req && acc_write && acc_to_target)
    else $error("holding register not flushed");
  a_auto_reload: assert property (
    do_exp && amode[dbpc_pkg::MD_AUTO] && !cmd_mclr
    |=> cur_cnt_q[$past(act_ch_q)] == base_cnt_q[$past(act_ch_q)])
    else $error("autoinit reload missing");

  c_chain_entry: cover property (
    wr && ix == dbpc_pkg::IX_CHAIN && pwdata[0]);
  c_partial_flush: cover property (
    state_q == dbpc_pkg::S_STORE && acc_bytes < 3'd4 && acc_ack);
  c_auto_expire: cover property (do_exp && amode[dbpc_pkg::MD_AUTO]);

endmodule

// ### tb/dbpc_agent.sv
// dbpc_agent: memory-side agent on the access port of the controller.
// assumes the controller's pclk; fetched byte = address low byte ^ 5a.
`timescale 1ns/1ns
module dbpc_agent (
  // clock
  input  wire logic        pclk,
  // access port
  input  wire logic        acc_req,
  input  wire logic [31:0] acc_addr,
  output logic             acc_ack,
  output logic      [7:0]  acc_rdata
);
  int wait_q;
  initial
  begin
    acc_ack = 1'b0;
    acc_rdata = 8'h00;
    wait_q = 0;
  end
  // answers at once or after up to two idle cycles
  always @(posedge pclk)
  begin
    if (acc_req && !acc_ack && wait_q == 0)
    begin
      acc_ack <= 1'b1;
      acc_rdata <= acc_addr[7:0] ^ 8'h5a;
      wait_q <= $urandom % 3;
    end
    else
    begin
      acc_ack <= 1'b0;
      acc_rdata <= ~acc_rdata;
      if (wait_q > 0)
        wait_q <= wait_q - 1;
    end
  end
endmodule

// ### tb/dbpc_ctrl_tb.sv
// dbpc_ctrl_tb: self-checking bench of the buffer-process controller.
// assumes dbpc_agent on the access port; this module is the apb master.
`timescale 1ns/1ns
module dbpc_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, acc_addr, acc_wdata, rd, ra;
  logic [7:0]  channel_request_in, acc_rdata;
  logic        end_of_process_n, acc_req, acc_write, acc_to_target, acc_ack;
  logic [2:0]  acc_ch, acc_bytes;
  logic        chaining_interrupt, terminal_count, tc_irq;
  logic [34:0] exp_q[$];
  int          failures, n_checks, tcs;
  dbpc_ctrl #(.NCH(8)) dbpc_ctrl_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .channel_request_in, .end_of_process_n, .acc_req, .acc_write,
    .acc_to_target, .acc_ch, .acc_addr, .acc_wdata, .acc_bytes, .acc_ack,
    .acc_rdata, .chaining_interrupt, .terminal_count, .tc_irq);
  dbpc_agent dbpc_agent_i (.pclk, .acc_req, .acc_addr, .acc_ack, .acc_rdata);
  always #50 pclk = ~pclk;
  task automatic chk(input logic [34:0] seen, input logic [34:0] want);
    n_checks++;
    if (seen !== want)
    begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (!pready)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // channel 0: target 0x1234, count 8, requester ra, unmasked
  task automatic prog(input logic [7:0] md);
    apb(1, dbpc_pkg::IX_BPTR_CLR, $urandom);
    apb(1, dbpc_pkg::IX_CH_SEL, 0);
    apb(1, dbpc_pkg::IX_MODE1, {24'h0, md});
    apb(1, dbpc_pkg::IX_TGT_PAIR, 32'h0000_0034);
    apb(1, dbpc_pkg::IX_TGT_PAIR, 32'h0000_0012);
    apb(1, dbpc_pkg::IX_CNT_PAIR, 32'h0000_0008);
    apb(1, dbpc_pkg::IX_CNT_PAIR, 0);
    apb(1, dbpc_pkg::IX_REQ_ADDR, ra);
    apb(1, dbpc_pkg::IX_MASK0_CLR, $urandom);
  endtask
  // two full stores of fetched bytes, lane order kept
  task automatic push2();
    logic [31:0] v;
    for (int j = 0; j < 8; j++)
    begin
      v[8*(j%4) +: 8] = 8'(ra + j) ^ 8'h5a;
      if (j % 4 == 3)
        exp_q.push_back({3'd4, v});
    end
  endtask
  task automatic wait_tc(input int n);
    int k;
    k = 0;
    while (tcs < n && k < 300)
    begin
      k++;
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask
  always @(posedge pclk)
    if (terminal_count)
      tcs++;
  always @(posedge pclk)
    if (acc_req && acc_write && acc_ack)
    begin
      chk({acc_bytes, acc_wdata}, exp_q.size() ? exp_q.pop_front() : '1);
      chk({acc_ch, acc_to_target}, 4'b0001);
    end
  initial
  begin
    #(100 * 20000);
    failures++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(1));
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    channel_request_in = '0;
    end_of_process_n = 1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(chaining_interrupt | tc_irq, 0);
    apb(0, 10'h3ff, 0);
    chk({err, rd}, 33'h1_0000_0000);
    ra = $urandom;
    prog(8'h80);
    apb(1, dbpc_pkg::IX_BPTR_CLR, $urandom);
    apb(0, dbpc_pkg::IX_TGT_PAIR, 0);
    chk(rd[7:0], 8'h34);
    apb(0, dbpc_pkg::IX_TGT_PAIR, 0);
    chk(rd[7:0], 8'h12);
    push2();
    apb(1, dbpc_pkg::IX_SWREQ, 1);
    wait_tc(1);
    chk(tc_irq, 1);
    apb(1, dbpc_pkg::IX_TCIRQ_CLR, $urandom);
    chk(tc_irq, 0);
    apb(1, dbpc_pkg::IX_SWREQ, 1);
    wait_tc(2);
    chk(tcs, 1);
    apb(1, dbpc_pkg::IX_SWREQ, 0);
    prog(8'h90);
    repeat (2)
    begin
      push2();
      apb(1, dbpc_pkg::IX_SWREQ, 1);
      wait_tc(tcs + 1);
    end
    chk(tcs, 3);
    prog(8'h80);
    apb(1, dbpc_pkg::IX_CHAIN, 1);
    chk(chaining_interrupt, 1);
    apb(1, dbpc_pkg::IX_TGT_B2, 0);
    chk(chaining_interrupt, 1);
    apb(1, dbpc_pkg::IX_TGT_B3, $urandom);
    chk(chaining_interrupt, 0);
    repeat (2)
    begin
      push2();
      apb(1, dbpc_pkg::IX_SWREQ, 1);
      wait_tc(tcs + 1);
      chk(chaining_interrupt, 1);
    end
    chk(tcs, 5);
    apb(0, dbpc_pkg::IX_MASK, 0);
    chk(rd[0], 1);
    apb(1, dbpc_pkg::IX_CHAIN, 0);
    apb(1, dbpc_pkg::IX_CHAIN, 1);
    apb(1, dbpc_pkg::IX_CHAIN, 0);
    chk(chaining_interrupt, 0);
    apb(1, dbpc_pkg::IX_CHAIN, 1);
    apb(1, dbpc_pkg::IX_MCLR, $urandom);
    chk(chaining_interrupt, 0);
    prog(8'h90);
    end_of_process_n <= 1'b0;
    exp_q.push_back({3'd1, 24'h0, 8'(ra) ^ 8'h5a});
    apb(1, dbpc_pkg::IX_SWREQ, 1);
    wait_tc(tcs + 1);
    apb(1, dbpc_pkg::IX_MODE1, 32'h0000_0091);
    apb(1, dbpc_pkg::IX_SWREQ, 1);
    wait_tc(tcs + 1);
    apb(0, dbpc_pkg::IX_HOLD, 0);
    chk(rd, {24'h0, 8'h34 ^ 8'h5a});
    end_of_process_n <= 1'b1;
    prog(8'hc0);
    apb(1, dbpc_pkg::IX_SWREQ, 1);
    wait_tc(tcs + 1);
    chk(tcs, 7);
    chk(exp_q.size(), 0);
    wrap_up();
  end
endmodule
